// ==== src/asp_pkg.sv ====
`default_nettype none

package asp_pkg;

  // register indices; byte address is four times the index
  localparam logic [12:0] ASP_IDX_ANALOG_LATCH = 13'h0007;
  localparam logic [12:0] ASP_IDX_ANALOG_DIR = 13'h1F8D;
  localparam logic [12:0] ASP_IDX_GPA_LATCH = 13'h0008;
  localparam logic [12:0] ASP_IDX_GPB_LATCH = 13'h0009;
  localparam logic [12:0] ASP_IDX_GPA_DIR = 13'h1F8E;
  localparam logic [12:0] ASP_IDX_GPB_DIR = 13'h1F8F;
  localparam logic [12:0] ASP_IDX_GPA_DRV = 13'h1F90;
  localparam logic [12:0] ASP_IDX_GPB_DRV = 13'h1F91;
  localparam logic [12:0] ASP_IDX_CONV_CTRL = 13'h0010;

  // address bit that selects the read-modify-write view of a read
  localparam int ASP_RMW_ALIAS_BIT = 15;

  // converter control a fields
  localparam int ASP_CCA_DIS_BIT = 0;
  localparam int ASP_CCA_SEL_LSB = 1;
  localparam int ASP_CCA_SEL_W = 3;

  // reset values
  localparam logic [7:0] ASP_PORT_RESET = 8'h00;
  localparam logic [7:0] ASP_CCA_RESET = 8'h01;

  // ahb encodings
  localparam logic [1:0] ASP_HTRANS_NONSEQ = 2'h2;
  localparam logic ASP_HRESP_OKAY = 1'h0;

  // one port's pin drive: value and active-low output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } asp_pin_type;

endpackage

`default_nettype wire

// ==== src/asp_ports.sv ====
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: an analog-shared port bit with direction 1 drives its latch value onto the pin, with direction 0 it floats.
// R02: reset clears the analog-shared port direction and latch and sets the analog input disable bit to 1.
// R03: with direction 0, disable 1 and latch 0 is fixed low, latch 1 is digital input, disable 0 and latch 0 is analog.
// R04: a read of an analog-shared bit in analog input mode returns 0.
// R05: a read of an input bit whose latch is 0 returns 0 instead of the pin level.
// R06: software sets analog bits to latch 0 direction 0, then clearing the disable bit starts a conversion.
// R07: the sampled converter channel comes from the channel select field, not from the port registers.
// R08: software sets latch bit 7 to 1 to let the debug output reach pin 7.
// R09: a read-modify-write reads input bits from the pins and writes all eight latch bits back.
// R10: software avoids read-modify-write on the analog-shared port while any bit is an input.
// R11: software never sets a bit used for analog input to output direction.
// R12: software avoids output writes to the analog-shared port while a conversion runs.
// R13: each general port has an 8-bit direction and latch register, both reset to 0, leaving all pins inputs.
// R14: each general port bit has a driver select that resets to 0, tri-state.
// R15: for open-drain bits a read-modify-write read returns the latch, any other read the pin; here open-drain output bits always read the latch.
// R16: driver select 0 means tri-state push-pull and 1 means open-drain.
// R17: an open-drain output bit drives low for latch 0 and releases the pin for latch 1.
module asp_ports (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [7:0] analog_pin_in, // analog-shared pin levels
  input wire logic [7:0] gpa_pin_in, // general port a pin levels
  input wire logic [7:0] gpb_pin_in, // general port b pin levels
  input wire logic debug_output_two, // debug signal for pin 7
  output asp_pkg::asp_pin_type analog_pin, // analog-shared pin drive
  output asp_pkg::asp_pin_type gpa_pin, // general port a pin drive
  output asp_pkg::asp_pin_type gpb_pin, // general port b pin drive
  output logic [7:0] analog_enable, // per-bit analog input mode
  output logic [2:0] converter_channel, // sampled channel
  output logic conversion_start // one-cycle start pulse
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // register index from a byte address
  function automatic logic [12:0] reg_index(input logic [31:0] a);
    reg_index = a[14:2];
  endfunction

  // read view of one port; output bits and rmw open-drain bits show the latch
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin, input logic [7:0] od,
                                           input logic rmw);
    logic [7:0] from_latch;
    from_latch = dir | (od & {8{rmw}});
    port_read = (from_latch & latch) | (~from_latch & pin);
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] analog_port_output_latch;
  logic [7:0] analog_port_direction;
  logic [7:0] general_port_a_output_latch;
  logic [7:0] general_port_b_output_latch;
  logic [7:0] general_port_a_direction;
  logic [7:0] general_port_b_direction;
  logic [7:0] general_port_a_driver_select;
  logic [7:0] general_port_b_driver_select;
  logic [7:0] converter_control_a;
  logic analog_input_disable;
  logic [2:0] converter_channel_select;
  logic dis_q;

  assign analog_input_disable = converter_control_a[asp_pkg::ASP_CCA_DIS_BIT];
  assign converter_channel_select = converter_control_a[asp_pkg::ASP_CCA_SEL_LSB +: asp_pkg::ASP_CCA_SEL_W];

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic addr_phase;
  logic wr_pend;
  logic [12:0] wr_idx;
  logic [7:0] next_rdata;
  logic [12:0] rd_idx;
  logic rd_rmw;

  assign addr_phase = hsel && hready && (htrans == asp_pkg::ASP_HTRANS_NONSEQ || htrans[1]);
  assign rd_idx = reg_index(haddr);
  assign rd_rmw = haddr[asp_pkg::ASP_RMW_ALIAS_BIT];

  // zero-wait slave: always ready and okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp <= asp_pkg::ASP_HRESP_OKAY;
    end else begin
      hreadyout <= 1'h1;
      hresp <= asp_pkg::ASP_HRESP_OKAY;
    end
  end

  // capture a write address phase; the data arrives one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'h0;
      wr_idx <= 13'h0000;
    end else begin
      wr_pend <= addr_phase && hwrite;
      if (addr_phase && hwrite) begin
        wr_idx <= rd_idx;
      end
    end
  end

  // read mux; the analog port needs no rmw view because its read already
  // masks latch-0 inputs to 0 and analog bits to 0
  always_comb begin
    next_rdata = 8'h00;
    case (rd_idx)
      asp_pkg::ASP_IDX_ANALOG_LATCH: begin
        next_rdata = port_read(analog_port_direction, analog_port_output_latch, // R09
                               analog_pin_in & analog_port_output_latch, 8'h00, 1'h0); // R04 R05
      end
      asp_pkg::ASP_IDX_ANALOG_DIR: next_rdata = analog_port_direction;
      asp_pkg::ASP_IDX_GPA_LATCH: begin
        next_rdata = port_read(general_port_a_direction, general_port_a_output_latch,
                               gpa_pin_in, general_port_a_driver_select, rd_rmw); // R15
      end
      asp_pkg::ASP_IDX_GPB_LATCH: begin
        next_rdata = port_read(general_port_b_direction, general_port_b_output_latch,
                               gpb_pin_in, general_port_b_driver_select, rd_rmw); // R15
      end
      asp_pkg::ASP_IDX_GPA_DIR: next_rdata = general_port_a_direction;
      asp_pkg::ASP_IDX_GPB_DIR: next_rdata = general_port_b_direction;
      asp_pkg::ASP_IDX_GPA_DRV: next_rdata = general_port_a_driver_select;
      asp_pkg::ASP_IDX_GPB_DRV: next_rdata = general_port_b_driver_select;
      asp_pkg::ASP_IDX_CONV_CTRL: next_rdata = converter_control_a;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data is sampled at the address phase and stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h000000, next_rdata};
    end
  end

  // analog-shared port registers; a write always replaces all eight latch bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_port_output_latch <= asp_pkg::ASP_PORT_RESET; // R02
      analog_port_direction <= asp_pkg::ASP_PORT_RESET; // R02
      converter_control_a <= asp_pkg::ASP_CCA_RESET; // R02
    end else if (wr_pend) begin
      case (wr_idx)
        asp_pkg::ASP_IDX_ANALOG_LATCH: analog_port_output_latch <= hwdata[7:0]; // R09
        asp_pkg::ASP_IDX_ANALOG_DIR: analog_port_direction <= hwdata[7:0];
        asp_pkg::ASP_IDX_CONV_CTRL: converter_control_a <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // general port registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      general_port_a_output_latch <= asp_pkg::ASP_PORT_RESET; // R13
      general_port_b_output_latch <= asp_pkg::ASP_PORT_RESET; // R13
      general_port_a_direction <= asp_pkg::ASP_PORT_RESET; // R13
      general_port_b_direction <= asp_pkg::ASP_PORT_RESET; // R13
      general_port_a_driver_select <= asp_pkg::ASP_PORT_RESET; // R14
      general_port_b_driver_select <= asp_pkg::ASP_PORT_RESET; // R14
    end else if (wr_pend) begin
      case (wr_idx)
        asp_pkg::ASP_IDX_GPA_LATCH: general_port_a_output_latch <= hwdata[7:0];
        asp_pkg::ASP_IDX_GPB_LATCH: general_port_b_output_latch <= hwdata[7:0];
        asp_pkg::ASP_IDX_GPA_DIR: general_port_a_direction <= hwdata[7:0];
        asp_pkg::ASP_IDX_GPB_DIR: general_port_b_direction <= hwdata[7:0];
        asp_pkg::ASP_IDX_GPA_DRV: general_port_a_driver_select <= hwdata[7:0];
        asp_pkg::ASP_IDX_GPB_DRV: general_port_b_driver_select <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin and converter drive
  // ----------------------------------------
  // analog port: output bits drive the latch, pin 7 also gated by the debug signal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_pin.out <= 8'h00;
      analog_pin.oe_n <= 8'hFF;
    end else begin
      analog_pin.out <= analog_port_output_latch & {debug_output_two, 7'h7F}; // R01 R08
      analog_pin.oe_n <= ~analog_port_direction; // R01
    end
  end

  // general ports: open-drain bits drive only a low and release for latch 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpa_pin.out <= 8'h00;
      gpa_pin.oe_n <= 8'hFF;
      gpb_pin.out <= 8'h00;
      gpb_pin.oe_n <= 8'hFF;
    end else begin
      gpa_pin.out <= general_port_a_output_latch & ~general_port_a_driver_select; // R16 R17
      gpa_pin.oe_n <= ~(general_port_a_direction &
                        (~general_port_a_driver_select | ~general_port_a_output_latch)); // R17
      gpb_pin.out <= general_port_b_output_latch & ~general_port_b_driver_select; // R16 R17
      gpb_pin.oe_n <= ~(general_port_b_direction &
                        (~general_port_b_driver_select | ~general_port_b_output_latch)); // R17
    end
  end

  // converter side: analog mode per bit, channel select, start on disable falling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_enable <= 8'h00;
      converter_channel <= 3'h0;
      conversion_start <= 1'h0;
      dis_q <= 1'h1;
    end else begin
      analog_enable <= ~analog_port_direction & ~analog_port_output_latch &
                       ~{8{analog_input_disable}}; // R03
      converter_channel <= converter_channel_select; // R07
      dis_q <= analog_input_disable;
      conversion_start <= dis_q && !analog_input_disable; // R06
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_ANALOG_OE: assert property (@(posedge hclk) disable iff (!hresetn) // R01
    analog_pin.oe_n == ~$past(analog_port_direction)) else $error("analog pin enable wrong");

  AST_RESET_VALUES: assert property (@(posedge hclk) !hresetn |-> // R02
    analog_port_direction == 8'h00 && analog_port_output_latch == 8'h00 && analog_input_disable)
    else $error("analog reset values wrong");

  AST_ANALOG_MODE: assert property (@(posedge hclk) disable iff (!hresetn) // R03
    analog_input_disable |=> analog_enable == 8'h00) else $error("analog mode while disabled");

  AST_ANALOG_READ_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // R04
    addr_phase && !hwrite && rd_idx == asp_pkg::ASP_IDX_ANALOG_LATCH && !analog_input_disable |=>
    (hrdata[7:0] & ~$past(analog_port_direction) & ~$past(analog_port_output_latch)) == 8'h00)
    else $error("analog bit read non-zero");

  AST_LATCH_ZERO_READ: assert property (@(posedge hclk) disable iff (!hresetn) // R05
    addr_phase && !hwrite && rd_idx == asp_pkg::ASP_IDX_ANALOG_LATCH |=>
    (hrdata[7:0] & ~$past(analog_port_direction)) == ($past(analog_pin_in) & $past(analog_port_output_latch)
    & ~$past(analog_port_direction))) else $error("input read wrong");

  AST_CONV_START: assert property (@(posedge hclk) disable iff (!hresetn) // R06
    $fell(analog_input_disable) |=> conversion_start ##1 !conversion_start)
    else $error("conversion start missing");

  AST_CHANNEL: assert property (@(posedge hclk) disable iff (!hresetn) // R07
    converter_channel == $past(converter_channel_select)) else $error("channel not from select");

  AST_RMW_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // R09
    wr_pend && wr_idx == asp_pkg::ASP_IDX_ANALOG_LATCH |=> analog_port_output_latch == $past(hwdata[7:0]))
    else $error("latch write lost");

  AST_GP_RESET: assert property (@(posedge hclk) !hresetn |-> general_port_a_direction == 8'h00 && // R13
    general_port_b_direction == 8'h00 && general_port_a_output_latch == 8'h00 &&
    general_port_b_output_latch == 8'h00 && general_port_a_driver_select == 8'h00 &&
    general_port_b_driver_select == 8'h00) else $error("general port reset wrong");

  AST_OD_RMW_READ: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    addr_phase && !hwrite && rd_rmw && rd_idx == asp_pkg::ASP_IDX_GPA_LATCH |=>
    (hrdata[7:0] & $past(general_port_a_driver_select)) ==
    ($past(general_port_a_output_latch) & $past(general_port_a_driver_select)))
    else $error("rmw read not latch");

  // open-drain bits never drive a high; a bit drives only as an output that is not released
  AST_OD_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    (gpb_pin.out & $past(general_port_b_driver_select)) == 8'h00 &&
    gpb_pin.oe_n == ~($past(general_port_b_direction) & ~$past(general_port_b_output_latch) |
    $past(general_port_b_direction) & ~$past(general_port_b_driver_select)))
    else $error("open-drain drive wrong");

  AST_TRI_STATE_OUT: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (gpa_pin.out & ~$past(general_port_a_driver_select)) ==
    ($past(general_port_a_output_latch) & ~$past(general_port_a_driver_select)))
    else $error("push-pull bit does not show latch");

  // a start pulse must trace back to a falling disable bit two edges earlier
  AST_START_ONLY_ON_FALL: assert property (@(posedge hclk) disable iff (!hresetn) // R06
    conversion_start |-> $past(analog_input_disable, 2) && !$past(analog_input_disable))
    else $error("conversion start without disable falling");

  AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && hresp == asp_pkg::ASP_HRESP_OKAY) else $error("slave not ready or not okay");

endmodule

`default_nettype wire

// ==== tb/asp_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// far side: pin wires and analog converter
// ---------------------------------------------
module asp_far_side (
  input wire logic hclk, // system clock
  input wire logic hresetn, // reset, active low
  input wire logic [23:0] ext_level, // outside levels of released pins
  input wire asp_pkg::asp_pin_type analog_pin, // analog port drive
  input wire asp_pkg::asp_pin_type gpa_pin, // port a drive
  input wire asp_pkg::asp_pin_type gpb_pin, // port b drive
  input wire logic conversion_start, // start pulse
  input wire logic [2:0] converter_channel, // selected channel
  output logic [7:0] analog_pin_in, // analog pin levels
  output logic [7:0] gpa_pin_in, // port a levels
  output logic [7:0] gpb_pin_in, // port b levels
  output logic [7:0] start_count, // conversions begun
  output logic [2:0] sampled_channel // channel of the last start
);
  // driven bits show the driver; released ones the outside level, which the bench
  // holds high on released open-drain lines as a pull-up would
  assign analog_pin_in = (analog_pin.out & ~analog_pin.oe_n) | (ext_level[7:0] & analog_pin.oe_n);
  assign gpa_pin_in = (gpa_pin.out & ~gpa_pin.oe_n) | (ext_level[15:8] & gpa_pin.oe_n);
  assign gpb_pin_in = (gpb_pin.out & ~gpb_pin.oe_n) | (ext_level[23:16] & gpb_pin.oe_n);
  // the converter takes its channel from the select field, never from port state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_count <= 8'h00;
      sampled_channel <= 3'h0;
    end else if (conversion_start) begin
      start_count <= start_count + 8'h01;
      sampled_channel <= converter_channel;
    end
  end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// self-checking bench for the port block
// ---------------------------------------------
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic dbg = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [23:0] ext_level = 24'h0;
  logic hreadyout, hresp, conv_start;
  logic [31:0] hrdata, rd;
  logic [7:0] a_in, ga_in, gb_in, a_en, n_start;
  logic [2:0] chan, last_ch;
  asp_pkg::asp_pin_type a_pin, ga_pin, gb_pin;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h1c294447;
  int lat[3], dir[3], od[3], ext[3], cca, starts, sel;
  logic [12:0] regs[8] = '{asp_pkg::ASP_IDX_ANALOG_LATCH, asp_pkg::ASP_IDX_ANALOG_DIR,
    asp_pkg::ASP_IDX_GPA_LATCH, asp_pkg::ASP_IDX_GPB_LATCH, asp_pkg::ASP_IDX_GPA_DIR,
    asp_pkg::ASP_IDX_GPB_DIR, asp_pkg::ASP_IDX_GPA_DRV, asp_pkg::ASP_IDX_GPB_DRV};

  always #4 hclk = ~hclk;

  asp_ports u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .analog_pin_in(a_in), .gpa_pin_in(ga_in), .gpb_pin_in(gb_in),
    .debug_output_two(dbg), .analog_pin(a_pin), .gpa_pin(ga_pin), .gpb_pin(gb_pin),
    .analog_enable(a_en), .converter_channel(chan), .conversion_start(conv_start));

  asp_far_side u_far (.hclk(hclk), .hresetn(hresetn), .ext_level(ext_level), .analog_pin(a_pin),
    .gpa_pin(ga_pin), .gpb_pin(gb_pin), .conversion_start(conv_start), .converter_channel(chan),
    .analog_pin_in(a_in), .gpa_pin_in(ga_in), .gpb_pin_in(gb_in), .start_count(n_start),
    .sampled_channel(last_ch));

  // verdict and end of run, shared with the watchdog
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // compare helpers, one per kind of result
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: port outputs %h, expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; the master waits for ready at both phases with no assumed latency
  task automatic bus(input logic wr, input logic [31:0] addr, input int wd, output logic [31:0] rdat);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= asp_pkg::ASP_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [12:0] idx, input int val);
    bus(1'b1, {17'h0, idx, 2'b00}, val, rd);
  endtask

  // behavioural read view: outputs and rmw open-drain bits read the latch, others the pin; the analog port ands in the latch
  function automatic int exp_rd(input logic [12:0] idx, input int rmw);
    int p;
    int m;
    p = (idx == asp_pkg::ASP_IDX_GPA_LATCH) ? 1 : 2;
    m = dir[p] | (rmw != 0 ? od[p] : 0);
    case (idx)
      asp_pkg::ASP_IDX_ANALOG_LATCH: return lat[0] & (dir[0] | ext[0]);
      asp_pkg::ASP_IDX_ANALOG_DIR: return dir[0];
      asp_pkg::ASP_IDX_GPA_LATCH, asp_pkg::ASP_IDX_GPB_LATCH: return (m & lat[p]) | (~m & ext[p]);
      asp_pkg::ASP_IDX_GPA_DIR: return dir[1];
      asp_pkg::ASP_IDX_GPB_DIR: return dir[2];
      asp_pkg::ASP_IDX_GPA_DRV: return od[1];
      asp_pkg::ASP_IDX_GPB_DRV: return od[2];
      asp_pkg::ASP_IDX_CONV_CTRL: return cca;
      default: return 0;
    endcase
  endfunction

  task automatic rd_chk(input logic [12:0] idx, input int rmw);
    bus(1'b0, {16'h0, rmw[0], idx, 2'b00}, 0, rd);
    cmp_reg(rd, 32'(exp_rd(idx, rmw)));
  endtask

  // pin drive, analog mode, channel and conversion count against the model
  task automatic chk_pins;
    logic [7:0] dr;
    dr = 8'(dir[0]);
    cmp_out({a_pin.out & dr, a_pin.oe_n}, {8'(lat[0]) & dr & {dbg, 7'h7F}, ~dr});
    dr = 8'(dir[1] & ~(od[1] & lat[1]));
    cmp_out({ga_pin.out & dr, ga_pin.oe_n}, {8'(lat[1] & ~od[1]) & dr, ~dr});
    dr = 8'(dir[2] & ~(od[2] & lat[2]));
    cmp_out({gb_pin.out & dr, gb_pin.oe_n}, {8'(lat[2] & ~od[2]) & dr, ~dr});
    cmp_out({5'h0, chan, a_en}, {5'h0, 3'(cca >> 1), (cca & 1) != 0 ? 8'h00 : 8'(~(dir[0] | lat[0]))});
    cmp_out({n_start, 5'h0, last_ch}, {8'(starts), 5'h0, 3'(sel)});
    cmp_out({14'h0, hreadyout, hresp}, {14'h0, 1'b1, asp_pkg::ASP_HRESP_OKAY});
  endtask

  task automatic check_all;
    repeat (4) @(posedge hclk);
    chk_pins;
    foreach (regs[i]) rd_chk(regs[i], 0);
    rd_chk(asp_pkg::ASP_IDX_CONV_CTRL, 0);
    rd_chk(asp_pkg::ASP_IDX_GPA_LATCH, 1);
    rd_chk(asp_pkg::ASP_IDX_GPB_LATCH, 1);
    rd_chk(13'h0FFF, 0);
  endtask

  // outside levels change only while no transfer is in flight; released open-drain lines pulled high
  task automatic set_ext;
    for (int p = 0; p < 3; p++) ext[p] = ($random(seed) & 255) | (p > 0 ? od[p] & dir[p] : 0);
    ext_level <= {8'(ext[2]), 8'(ext[1]), 8'(ext[0])};
    dbg <= 1'($random(seed));
  endtask

  task automatic model_reset;
    for (int p = 0; p < 3; p++) begin
      lat[p] = 0;
      dir[p] = 0;
      od[p] = 0;
    end
    cca = 1;
    starts = 0;
    sel = 0;
  endtask

  // main sequence: reset state, random configurations, then a reset in mid-run
  initial begin
    // a real falling edge at time zero, so the asynchronous reset acts before the first clock
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    model_reset;
    set_ext;
    check_all;
    for (int it = 0; it < 16; it++) begin
      cca = cca | 1;
      wr(asp_pkg::ASP_IDX_CONV_CTRL, cca);
      for (int p = 0; p < 3; p++) begin
        lat[p] = $random(seed) & 255;
        dir[p] = $random(seed) & 255;
        od[p] = p > 0 ? $random(seed) & 255 : 0;
      end
      wr(asp_pkg::ASP_IDX_ANALOG_LATCH, lat[0]);
      wr(asp_pkg::ASP_IDX_ANALOG_DIR, dir[0]);
      wr(asp_pkg::ASP_IDX_GPA_LATCH, lat[1]);
      wr(asp_pkg::ASP_IDX_GPB_LATCH, lat[2]);
      wr(asp_pkg::ASP_IDX_GPA_DIR, dir[1]);
      wr(asp_pkg::ASP_IDX_GPB_DIR, dir[2]);
      wr(asp_pkg::ASP_IDX_GPA_DRV, od[1]);
      wr(asp_pkg::ASP_IDX_GPB_DRV, od[2]);
      wr(13'h0FFF, $random(seed));
      set_ext;
      cca = $random(seed) & 15;
      if ((cca & 1) == 0) begin
        starts++;
        sel = cca >> 1;
      end
      wr(asp_pkg::ASP_IDX_CONV_CTRL, cca);
      check_all;
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    model_reset;
    set_ext;
    check_all;
    print_verdict;
  end

  // watchdog well beyond the roughly 860 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    print_verdict;
  end
endmodule

`default_nettype wire
